// ---- logic/mdp_datapath.sv ----
// multiply and divide datapath top: one request in, register writes out
`timescale 1ns/10ps
// Contract
// - dual add sums two signed halfword products
// - exchange pairs bottom-top, else bottom-bottom
// - dual sub: bottom product minus top product
// - dual add sum overflow sets sticky flag
// - halfword selectors pick low or high half
// - halfword multiply writes full signed product
// - word by half writes top 32 of 48
// - unsigned long product split low and high
// - unsigned long accumulate adds destination pair
// - signed long product split low and high
// - signed long accumulate adds destination pair
// - long multiplies leave condition flags alone
// - divide truncates toward zero, signed or unsigned
// - missing destination writes the dividend register
// - divides never touch any flag
module mdp_datapath
  import mdp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic REQ_VALID_IN,
  input wire mdp_req_type REQ_IN,
  output logic REQ_READY_OUT,
  output logic RESULT_VALID_OUT,
  output mdp_result_type RESULT_OUT,
  output logic STICKY_OVERFLOW_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mdp_state_type fsm;
    logic valid;
    mdp_result_type result;
    logic [MDP_REG_W-1:0] div_dest;
  } mdp_top_state_type;

  mdp_top_state_type state_reg;
  mdp_top_state_type state_next;

  logic div_start;
  logic div_done;
  logic [31:0] div_quotient;
  logic is_divide;

  // ----------------------------------------------------------------
  // halfword selection
  // ----------------------------------------------------------------
  logic signed [15:0] first_lo;
  logic signed [15:0] first_hi;
  logic signed [15:0] second_lo;
  logic signed [15:0] second_hi;
  logic signed [15:0] pair_lo;
  logic signed [15:0] pair_hi;
  logic signed [15:0] sel_first;
  logic signed [15:0] sel_second;

  assign first_lo = REQ_IN.first_operand[MDP_HALF_LO +: MDP_HALF_W];
  assign first_hi = REQ_IN.first_operand[MDP_HALF_HI +: MDP_HALF_W];
  assign second_lo = REQ_IN.second_operand[MDP_HALF_LO +: MDP_HALF_W];
  assign second_hi = REQ_IN.second_operand[MDP_HALF_HI +: MDP_HALF_W];
  // exchange rotates the second operand's halves
  assign pair_lo = REQ_IN.exchange ? second_hi : second_lo;
  assign pair_hi = REQ_IN.exchange ? second_lo : second_hi;
  assign sel_first = REQ_IN.first_top ? first_hi : first_lo;
  assign sel_second = REQ_IN.second_top ? second_hi : second_lo;

  // ----------------------------------------------------------------
  // products and sums
  // ----------------------------------------------------------------
  logic signed [31:0] prod_lo;
  logic signed [31:0] prod_hi;
  logic signed [31:0] prod_half;
  logic signed [47:0] prod_word_half;
  logic signed [32:0] dual_sum;
  logic signed [32:0] dual_diff;
  logic [63:0] prod_unsigned;
  logic signed [63:0] prod_signed;
  logic [63:0] acc_pair;

  // 16x16 signed products cannot overflow 32 bits
  // operands are widened by size casts first, signed except for the unsigned long product, so no product leans on context sizing
  assign prod_lo = 32'(first_lo) * 32'(pair_lo);
  assign prod_hi = 32'(first_hi) * 32'(pair_hi);
  assign prod_half = 32'(sel_first) * 32'(sel_second);
  assign prod_word_half = 48'($signed(REQ_IN.first_operand)) * 48'(sel_second);
  // one guard bit shows whether the 32-bit sum overflowed
  assign dual_sum = 33'(prod_lo) + 33'(prod_hi);
  assign dual_diff = 33'(prod_lo) - 33'(prod_hi);
  assign prod_unsigned = 64'(REQ_IN.first_operand) * 64'(REQ_IN.second_operand);
  assign prod_signed = 64'($signed(REQ_IN.first_operand))
                       * 64'($signed(REQ_IN.second_operand));
  // accumulator is the 64-bit value held in the destination pair
  assign acc_pair = {REQ_IN.acc_high, REQ_IN.acc_low};
  // a divide starts only from idle; the divider captures its operands at the take
  assign is_divide = (REQ_IN.op == MDP_OP_SIGNED_DIVIDE) || (REQ_IN.op == MDP_OP_UNSIGNED_DIVIDE);
  assign div_start = REQ_VALID_IN && (state_reg.fsm == MDP_ST_IDLE) && is_divide;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  mdp_divider u_divider (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .start_in(div_start),
    .signed_in(REQ_IN.op == MDP_OP_SIGNED_DIVIDE),
    .dividend_in(REQ_IN.first_operand),
    .divisor_in(REQ_IN.second_operand),
    .done_out(div_done),
    .quotient_out(div_quotient)
  );

  // ----------------------------------------------------------------
  // next state: multiplies finish in one cycle, divides take 33 more
  // ----------------------------------------------------------------
  always_comb begin
    logic [63:0] long_val;
    long_val = 64'h0;
    state_next = state_reg;
    state_next.valid = 1'b0;
    state_next.result.overflow_set = 1'b0;
    case (state_reg.fsm)
      MDP_ST_IDLE: begin
        if (REQ_VALID_IN) begin
          state_next.result.write_low = 1'b1;
          state_next.result.write_high = 1'b0;
          state_next.result.low_reg = REQ_IN.dest;
          state_next.result.high_reg = REQ_IN.high_destination;
          state_next.result.high_data = MDP_WORD_RESET;
          state_next.valid = 1'b1;
          case (REQ_IN.op)
            MDP_OP_DUAL_MUL_ADD: begin
              state_next.result.low_data = dual_sum[31:0];
              // sign of the 33-bit sum differs from bit 31 on overflow
              state_next.result.overflow_set = dual_sum[32] ^ dual_sum[31];
            end
            MDP_OP_DUAL_MUL_SUB: begin
              state_next.result.low_data = dual_diff[31:0];
            end
            MDP_OP_HALFWORD_SIGNED_MUL: begin
              state_next.result.low_data = prod_half;
            end
            MDP_OP_WORD_BY_HALF_SIGNED_MUL: begin
              state_next.result.low_data = prod_word_half[47:16];
            end
            MDP_OP_UNSIGNED_LONG_MUL,
            MDP_OP_UNSIGNED_LONG_MUL_ACC,
            MDP_OP_SIGNED_LONG_MUL,
            MDP_OP_SIGNED_LONG_MUL_ACC: begin
              if (REQ_IN.op == MDP_OP_UNSIGNED_LONG_MUL) long_val = prod_unsigned;
              else if (REQ_IN.op == MDP_OP_UNSIGNED_LONG_MUL_ACC)
                long_val = prod_unsigned + acc_pair;
              else if (REQ_IN.op == MDP_OP_SIGNED_LONG_MUL) long_val = prod_signed;
              else long_val = prod_signed + acc_pair;
              // relies on distinct high and low registers from the issuer
              state_next.result.low_reg = REQ_IN.low_destination;
              state_next.result.write_high = 1'b1;
              state_next.result.low_data = long_val[31:0];
              state_next.result.high_data = long_val[63:32];
              // no flag update for long forms
            end
            MDP_OP_SIGNED_DIVIDE,
            MDP_OP_UNSIGNED_DIVIDE: begin
              state_next.valid = 1'b0;
              state_next.result.write_low = 1'b0;
              state_next.fsm = MDP_ST_DIVIDE;
              // absent destination falls back to the dividend register
              state_next.div_dest = REQ_IN.dest_present ? REQ_IN.dest
                                    : REQ_IN.first_operand_register;
            end
            default: begin
              // unknown codes are taken and produce no write
              state_next.valid = 1'b0;
              state_next.result.write_low = 1'b0;
            end
          endcase
        end
      end
      MDP_ST_DIVIDE: begin
        if (div_done) begin
          state_next.fsm = MDP_ST_DONE;
          state_next.valid = 1'b1;
          state_next.result.write_low = 1'b1;
          state_next.result.write_high = 1'b0;
          state_next.result.low_reg = state_reg.div_dest;
          state_next.result.low_data = div_quotient;
          // overflow_set stays low for divides
        end
      end
      MDP_ST_DONE: begin
        // one dead cycle keeps ready low during the quotient pulse
        state_next.fsm = MDP_ST_IDLE;
      end
      default: begin
        state_next.fsm = MDP_ST_IDLE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) state_reg <= '0;
    else state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // operands are register values; stack pointer and counter are kept out upstream
  assign REQ_READY_OUT = (state_reg.fsm == MDP_ST_IDLE);
  // result fields are registered; all except overflow_set hold until the next request is taken or a quotient is written
  assign RESULT_VALID_OUT = state_reg.valid;
  assign RESULT_OUT = state_reg.result;
  // a one-cycle set request; the sticky flag itself lives outside this block
  assign STICKY_OVERFLOW_OUT = state_reg.valid && state_reg.result.overflow_set;

endmodule : mdp_datapath

// ---- logic/mdp_pkg.sv ----
// package for the multiply and divide datapath: operation codes, widths, carriers
package mdp_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int MDP_WORD_W = 32;
  localparam int MDP_HALF_W = 16;
  localparam int MDP_REG_W = 4;
  localparam int MDP_HALF_LO = 0;
  localparam int MDP_HALF_HI = 16;
  localparam int MDP_DIV_STEPS = 32;
  localparam logic [5:0] MDP_DIV_LAST = 6'h1f;
  localparam logic [MDP_REG_W-1:0] MDP_REG_RESET = 4'h0;
  localparam logic [31:0] MDP_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] MDP_SIGNED_MIN = 32'h8000_0000;
  localparam logic [31:0] MDP_MINUS_ONE = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MDP_OP_DUAL_MUL_ADD = 4'h0,
    MDP_OP_DUAL_MUL_SUB = 4'h1,
    MDP_OP_HALFWORD_SIGNED_MUL = 4'h2,
    MDP_OP_WORD_BY_HALF_SIGNED_MUL = 4'h3,
    MDP_OP_UNSIGNED_LONG_MUL = 4'h4,
    MDP_OP_UNSIGNED_LONG_MUL_ACC = 4'h5,
    MDP_OP_SIGNED_LONG_MUL = 4'h6,
    MDP_OP_SIGNED_LONG_MUL_ACC = 4'h7,
    MDP_OP_SIGNED_DIVIDE = 4'h8,
    MDP_OP_UNSIGNED_DIVIDE = 4'h9
  } mdp_op_type;

  // controller states, gray along idle -> divide -> done
  typedef enum logic [1:0] {
    MDP_ST_IDLE = 2'b00,
    MDP_ST_DIVIDE = 2'b01,
    MDP_ST_DONE = 2'b11
  } mdp_state_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    mdp_op_type op;
    logic exchange;
    logic first_top;
    logic second_top;
    logic dest_present;
    logic [MDP_REG_W-1:0] dest;
    logic [MDP_REG_W-1:0] first_operand_register;
    logic [MDP_REG_W-1:0] low_destination;
    logic [MDP_REG_W-1:0] high_destination;
    logic [MDP_WORD_W-1:0] first_operand;
    logic [MDP_WORD_W-1:0] second_operand;
    logic [MDP_WORD_W-1:0] acc_low;
    logic [MDP_WORD_W-1:0] acc_high;
  } mdp_req_type;

  typedef struct packed {
    logic write_low;
    logic write_high;
    logic [MDP_REG_W-1:0] low_reg;
    logic [MDP_REG_W-1:0] high_reg;
    logic [MDP_WORD_W-1:0] low_data;
    logic [MDP_WORD_W-1:0] high_data;
    logic overflow_set;
  } mdp_result_type;

endpackage : mdp_pkg

// ---- logic/mdp_divider.sv ----
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module mdp_divider
  import mdp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic signed_in,
  input wire logic [31:0] dividend_in,
  input wire logic [31:0] divisor_in,
  output logic done_out,
  output logic [31:0] quotient_out
);

  typedef struct packed {
    logic busy;
    logic done;
    logic negate;
    logic [5:0] count;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] div;
  } mdp_div_state_type;

  mdp_div_state_type state_reg;
  mdp_div_state_type state_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // magnitudes are divided and the sign applied last, which truncates toward zero
  always_comb begin
    logic [32:0] trial;
    logic [31:0] num;
    logic [31:0] den;
    trial = 33'h0_0000_0000;
    num = dividend_in;
    den = divisor_in;
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start_in) begin
      if (signed_in && dividend_in[31]) num = 32'h0 - dividend_in;
      if (signed_in && divisor_in[31]) den = 32'h0 - divisor_in;
      state_next.busy = 1'b1;
      state_next.count = 6'h00;
      state_next.rem = 32'h0;
      state_next.quo = num;
      state_next.div = den;
      state_next.negate = signed_in && (dividend_in[31] ^ divisor_in[31]);
    end else if (state_reg.busy) begin
      trial = {state_reg.rem, state_reg.quo[31]} - {1'b0, state_reg.div};
      if (!trial[32]) begin
        state_next.rem = trial[31:0];
        state_next.quo = {state_reg.quo[30:0], 1'b1};
      end else begin
        state_next.rem = {state_reg.rem[30:0], state_reg.quo[31]};
        state_next.quo = {state_reg.quo[30:0], 1'b0};
      end
      state_next.count = state_reg.count + 6'h01;
      if (state_reg.count == MDP_DIV_LAST) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        // zero divisor gives zero, never a fault; min / -1 wraps to min
        if (state_reg.div == 32'h0) begin
          state_next.quo = 32'h0;
        end else if (state_reg.negate) begin
          state_next.quo = 32'h0 - state_next.quo;
        end
      end
    end
  end

  // register the state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) state_reg <= '0;
    else state_reg <= state_next;
  end

  assign done_out = state_reg.done;
  assign quotient_out = state_reg.quo;

endmodule : mdp_divider

// ---- testbench/mdp_datapath_monitor.sv ----
// checker for the datapath ports: latencies, flags and register pairing
`timescale 1ns/10ps
module mdp_datapath_monitor
  import mdp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic REQ_VALID_IN,
  input wire mdp_req_type REQ_IN,
  input wire logic REQ_READY_OUT,
  input wire logic RESULT_VALID_OUT,
  input wire mdp_result_type RESULT_OUT,
  input wire logic STICKY_OVERFLOW_OUT
);
  logic take;
  logic is_div;
  logic is_long;
  logic dual_ovf;
  logic signed [15:0] a_lo;
  logic signed [15:0] a_hi;
  logic signed [15:0] b_lo;
  logic signed [15:0] b_hi;
  logic signed [32:0] dual_sum;
  logic [31:0] dual_add;
  logic [31:0] dual_diff;
  // reference dual products; 33 bits so the sum overflow is visible
  always_comb begin
    take = REQ_VALID_IN && REQ_READY_OUT;
    is_div = REQ_IN.op inside {MDP_OP_SIGNED_DIVIDE, MDP_OP_UNSIGNED_DIVIDE};
    is_long = REQ_IN.op[3:2] == 2'b01;
    a_lo = REQ_IN.first_operand[15:0];
    a_hi = REQ_IN.first_operand[31:16];
    b_lo = REQ_IN.exchange ? REQ_IN.second_operand[31:16] : REQ_IN.second_operand[15:0];
    b_hi = REQ_IN.exchange ? REQ_IN.second_operand[15:0] : REQ_IN.second_operand[31:16];
    dual_sum = a_lo * b_lo + a_hi * b_hi;
    dual_add = dual_sum[31:0];
    dual_diff = a_lo * b_lo - a_hi * b_hi;
    dual_ovf = dual_sum[32] ^ dual_sum[31];
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  property p_dual_add;
    take && REQ_IN.op == MDP_OP_DUAL_MUL_ADD |=> RESULT_VALID_OUT &&
      RESULT_OUT.low_data == $past(dual_add) && STICKY_OVERFLOW_OUT == $past(dual_ovf);
  endproperty
  a_dual_add: assert property (p_dual_add) else $error("dual add result wrong");
  property p_dual_sub;
    take && REQ_IN.op == MDP_OP_DUAL_MUL_SUB |=> RESULT_VALID_OUT && !STICKY_OVERFLOW_OUT &&
      RESULT_OUT.low_data == $past(dual_diff);
  endproperty
  a_dual_sub: assert property (p_dual_sub) else $error("dual sub result wrong");
  property p_sticky_pulse;
    STICKY_OVERFLOW_OUT |-> RESULT_VALID_OUT && RESULT_OUT.overflow_set;
  endproperty
  a_sticky_pulse: assert property (p_sticky_pulse) else $error("stray overflow");
  property p_half_dest;
    take && REQ_IN.op inside {MDP_OP_HALFWORD_SIGNED_MUL, MDP_OP_WORD_BY_HALF_SIGNED_MUL} |=>
      RESULT_OUT.write_low && !RESULT_OUT.write_high && RESULT_OUT.low_reg == $past(REQ_IN.dest);
  endproperty
  a_half_dest: assert property (p_half_dest) else $error("halfword write wrong");
  property p_long_pair;
    take && is_long |=> RESULT_OUT.write_low && RESULT_OUT.write_high &&
      RESULT_OUT.low_reg == $past(REQ_IN.low_destination) &&
      RESULT_OUT.high_reg == $past(REQ_IN.high_destination);
  endproperty
  a_long_pair: assert property (p_long_pair) else $error("long pair wrong");
  property p_long_flag;
    take && is_long |=> RESULT_VALID_OUT && !STICKY_OVERFLOW_OUT;
  endproperty
  a_long_flag: assert property (p_long_flag) else $error("long op touched flag");
  property p_div_busy;
    take && is_div |=> (!REQ_READY_OUT && !RESULT_VALID_OUT) [*8];
  endproperty
  a_div_busy: assert property (p_div_busy) else $error("divide not busy");
  property p_div_answer;
    take && is_div |-> ##34 RESULT_VALID_OUT && !STICKY_OVERFLOW_OUT;
  endproperty
  a_div_answer: assert property (p_div_answer) else $error("divide answer late");
  property p_div_dest;
    take && is_div && !REQ_IN.dest_present |->
      ##34 RESULT_OUT.low_reg == $past(REQ_IN.first_operand_register, 34);
  endproperty
  a_div_dest: assert property (p_div_dest) else $error("divide dest wrong");
endmodule : mdp_datapath_monitor

bind mdp_datapath mdp_datapath_monitor mon_u (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .RESULT_VALID_OUT(RESULT_VALID_OUT),
  .RESULT_OUT(RESULT_OUT), .STICKY_OVERFLOW_OUT(STICKY_OVERFLOW_OUT)
);

// ---- testbench/mdp_issuer.sv ----
// pipeline model: issues one decoded request and holds it until taken
`timescale 1ns/10ps
module mdp_issuer
  import mdp_pkg::*;
(
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out = 1'b0,
  output mdp_req_type req_out = '0,
  output logic stuck_out = 1'b0
);
  // registers 13 to 15 are never named; fold them into the low bank
  function automatic logic [3:0] fix_reg(input logic [3:0] x);
    return (x >= 4'hd) ? {1'b0, x[2:0]} : x;
  endfunction : fix_reg
  task automatic issue(input mdp_req_type r);
    mdp_req_type s;
    int n;
    s = r;
    s.dest = fix_reg(r.dest);
    s.first_operand_register = fix_reg(r.first_operand_register);
    s.low_destination = fix_reg(r.low_destination);
    s.high_destination = fix_reg(r.high_destination);
    if (s.high_destination == s.low_destination) begin
      s.high_destination = {~s.low_destination[3], ~s.low_destination[2:0]} & 4'h7;
    end
    n = 0;
    @(negedge clk_in);
    valid_out = 1'b1;
    req_out = s;
    // ready is stable from the falling edge to the sampling edge
    while (ready_in !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    stuck_out = (ready_in !== 1'b1);
    @(posedge clk_in);
    @(negedge clk_in);
    valid_out = 1'b0;
    // released lines show inverted values, never the stale request
    req_out = ~s;
  endtask : issue
endmodule : mdp_issuer

// ---- testbench/mdp_datapath_tb.sv ----
// testbench: every operation kind through the pipeline model, results checked
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module mdp_datapath_tb
  import mdp_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid;
  logic ready;
  logic rv;
  logic sticky;
  logic stuck;
  mdp_req_type req;
  mdp_result_type res;
  int miscompares = 0;
  int checks = 0;
  // 50 MHz core clock
  always #10 clk = ~clk;
  mdp_issuer issuer_u (.clk_in(clk), .ready_in(ready), .valid_out(valid), .req_out(req),
    .stuck_out(stuck));
  mdp_datapath dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(valid), .REQ_IN(req),
    .REQ_READY_OUT(ready), .RESULT_VALID_OUT(rv), .RESULT_OUT(res), .STICKY_OVERFLOW_OUT(sticky));
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // expected writes built independently; divides kept out of ternaries to stay signed
  function automatic mdp_result_type expect_of(input mdp_req_type r);
    mdp_result_type x;
    logic signed [15:0] a0;
    logic signed [15:0] a1;
    logic signed [15:0] p0;
    logic signed [15:0] p1;
    logic signed [15:0] bs;
    logic signed [32:0] s;
    logic signed [63:0] w;
    logic [63:0] u;
    x = '0;
    a0 = r.first_operand[15:0];
    a1 = r.first_operand[31:16];
    p0 = r.exchange ? r.second_operand[31:16] : r.second_operand[15:0];
    p1 = r.exchange ? r.second_operand[15:0] : r.second_operand[31:16];
    bs = r.second_top ? r.second_operand[31:16] : r.second_operand[15:0];
    s = a0 * p0 + a1 * p1;
    w = $signed(r.first_operand) * $signed(r.second_operand);
    u = {32'h0, r.first_operand} * {32'h0, r.second_operand};
    x.write_low = 1'b1;
    x.low_reg = r.dest;
    case (r.op)
      MDP_OP_DUAL_MUL_ADD: {x.overflow_set, x.low_data} = {s[32] ^ s[31], s[31:0]};
      MDP_OP_DUAL_MUL_SUB: x.low_data = a0 * p0 - a1 * p1;
      MDP_OP_HALFWORD_SIGNED_MUL: x.low_data = (r.first_top ? a1 : a0) * bs;
      MDP_OP_WORD_BY_HALF_SIGNED_MUL: begin
        w = $signed(r.first_operand) * bs;
        x.low_data = w[47:16];
      end
      MDP_OP_UNSIGNED_LONG_MUL, MDP_OP_UNSIGNED_LONG_MUL_ACC: begin
        if (r.op[0]) u = u + {r.acc_high, r.acc_low};
        {x.high_data, x.low_data} = u;
      end
      MDP_OP_SIGNED_LONG_MUL, MDP_OP_SIGNED_LONG_MUL_ACC: begin
        if (r.op[0]) w = w + $signed({r.acc_high, r.acc_low});
        {x.high_data, x.low_data} = w;
      end
      default: begin
        if (!r.dest_present) x.low_reg = r.first_operand_register;
        if (r.second_operand == 32'h0) x.low_data = 32'h0;
        else if (r.op[0]) x.low_data = r.first_operand / r.second_operand;
        else if (r.first_operand == MDP_SIGNED_MIN && r.second_operand == MDP_MINUS_ONE)
          x.low_data = MDP_SIGNED_MIN;
        else x.low_data = $signed(r.first_operand) / $signed(r.second_operand);
      end
    endcase
    if (r.op[3:2] == 2'b01) begin
      {x.write_high, x.low_reg} = {1'b1, r.low_destination};
      x.high_reg = r.high_destination;
    end
    return x;
  endfunction : expect_of
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    `CHK({ready, rv, sticky, res}, {3'b100, {$bits(res){1'b0}}})
  endtask : do_reset
  // flags are exchange, first_top, second_top, dest_present
  task automatic run_op(input mdp_op_type op, input logic [3:0] fl, input logic [31:0] a,
    input logic [31:0] b, input logic [63:0] acc);
    mdp_req_type r;
    mdp_result_type e;
    int n;
    r = '0;
    r.op = op;
    {r.exchange, r.first_top, r.second_top, r.dest_present} = fl;
    {r.dest, r.first_operand_register, r.low_destination, r.high_destination} = 16'h2534;
    {r.first_operand, r.second_operand, r.acc_high, r.acc_low} = {a, b, acc};
    e = expect_of(r);
    issuer_u.issue(r);
    // issue returns half a cycle after the take edge, so count that cycle as the first
    n = 1;
    while (n < 41 && rv !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rv !== 1'b1 || stuck !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
    `CHK(n, (op[3] ? 34 : 1))
    `CHK({res.write_low, res.write_high}, {e.write_low, e.write_high})
    `CHK(res.low_reg, e.low_reg)
    `CHK(res.low_data, e.low_data)
    `CHK({res.overflow_set, sticky}, {2{e.overflow_set}})
    if (e.write_high) begin
      `CHK(res.high_reg, e.high_reg)
      `CHK(res.high_data, e.high_data)
    end
  endtask : run_op
  initial begin
    do_reset();
    run_op(MDP_OP_DUAL_MUL_ADD, 4'h1, 32'h0003_0002, 32'h0005_0004, 64'h0);
    run_op(MDP_OP_DUAL_MUL_ADD, 4'h9, 32'h0003_0002, 32'h0005_0004, 64'h0);
    run_op(MDP_OP_DUAL_MUL_ADD, 4'h1, 32'h8000_8000, 32'h8000_8000, 64'h0);
    run_op(MDP_OP_DUAL_MUL_SUB, 4'h1, 32'h0003_0002, 32'h0005_0004, 64'h0);
    run_op(MDP_OP_DUAL_MUL_SUB, 4'h9, 32'h8000_7fff, 32'h8000_8000, 64'h0);
    for (int i = 0; i < 4; i++) begin
      run_op(MDP_OP_HALFWORD_SIGNED_MUL, {1'b0, 2'(i), 1'b1}, 32'hfffe_0003,
        32'h7fff_8000, 64'h0);
    end
    run_op(MDP_OP_WORD_BY_HALF_SIGNED_MUL, 4'h3, 32'h8000_0001,
      32'h8000_7fff, 64'h0);
    run_op(MDP_OP_WORD_BY_HALF_SIGNED_MUL, 4'h1, 32'h8000_0001,
      32'h8000_7fff, 64'h0);
    run_op(MDP_OP_UNSIGNED_LONG_MUL, 4'h1, 32'hffff_ffff, 32'hffff_ffff, 64'h0);
    run_op(MDP_OP_UNSIGNED_LONG_MUL_ACC, 4'h1, 32'hffff_ffff, 32'hffff_ffff, '1);
    run_op(MDP_OP_SIGNED_LONG_MUL, 4'h1, 32'h8000_0000, 32'h7fff_ffff, 64'h0);
    run_op(MDP_OP_SIGNED_LONG_MUL_ACC, 4'h1, 32'hffff_fff9, 32'h3, 64'hffff_fff0);
    run_op(MDP_OP_SIGNED_DIVIDE, 4'h1, 32'hffff_fff9, 32'h2, 64'h0);
    run_op(MDP_OP_UNSIGNED_DIVIDE, 4'h1, 32'hffff_fff9, 32'h2, 64'h0);
    run_op(MDP_OP_SIGNED_DIVIDE, 4'h0, 32'h7, 32'hffff_fffe, 64'h0);
    run_op(MDP_OP_UNSIGNED_DIVIDE, 4'h1, 32'h1234, 32'h0, 64'h0);
    run_op(MDP_OP_SIGNED_DIVIDE, 4'h1, MDP_SIGNED_MIN, MDP_MINUS_ONE, 64'h0);
    do_reset();
    run_op(MDP_OP_DUAL_MUL_ADD, 4'h9, 32'h7fff_8000, 32'h8000_7fff, 64'h0);
    give_verdict();
  end
endmodule : mdp_datapath_tb
